// ===== uvt_pkg.sv
// Shared constants and state encoding for the vendor test command decoder
`default_nettype none
package uvt_pkg;
  // Vendor sub-command codes and memory source selector
  localparam logic [7:0]  SUB_CFG       = 8'h26;
  localparam logic [7:0]  SUB_PIN       = 8'h27;
  localparam logic [7:0]  SRC_SERIAL    = 8'h02;
  // Configuration image layout
  localparam logic [7:0]  SIG0_ADDR     = 8'h00;
  localparam logic [7:0]  SIG1_ADDR     = 8'h01;
  localparam logic [7:0]  TAG_ADDR      = 8'h04;
  localparam logic [7:0]  TAG_DEFAULT   = 8'h24;
  localparam logic [7:0]  CFG_START     = 8'h00;
  // Transfer limits
  localparam logic [31:0] CFG_MAX_LEN   = 32'h0000_00ff;
  localparam logic [31:0] PIN_DATA_LEN  = 32'h0000_0004;
  // Two-wire memory addressing
  localparam logic [3:0]  MEM_DEV_BASE  = 4'ha;
  localparam logic [2:0]  PHYS_ADDR_A   = 3'h2;
  localparam logic [2:0]  PHYS_ADDR_B   = 3'h4;
  // Test byte 0 field positions
  localparam int B0_RST    = 7;
  localparam int B0_DA2    = 6;
  localparam int B0_CS_HI  = 5;
  localparam int B0_CS_LO  = 4;
  localparam int B0_PWR    = 3;
  localparam int B0_DA_HI  = 2;
  localparam int B0_DA_LO  = 1;
  localparam int B0_IRQ    = 0;
  // Test byte 1 field positions
  localparam int B1_DD_OE  = 7;
  localparam int B1_MODE   = 6;
  localparam int B1_VBUS   = 5;
  localparam int B1_DMARQ  = 4;
  localparam int B1_IORDY  = 3;
  localparam int B1_DMACK  = 2;
  localparam int B1_DIOR   = 1;
  localparam int B1_DIOW   = 0;
  // Loaded pin byte reset values
  localparam logic [7:0]  LD0_RESET     = 8'hb8;
  localparam logic [7:0]  LD1_RESET     = 8'h07;
  localparam logic [7:0]  LD_DD_RESET   = 8'h00;
  // Decoder states
  typedef enum logic [3:0] {
    ST_STRAP   = 4'h0,
    ST_BOOT    = 4'h1,
    ST_IDLE    = 4'h2,
    ST_CFG_WR  = 4'h3,
    ST_CFG_WM  = 4'h4,
    ST_CFG_RM  = 4'h5,
    ST_CFG_RS  = 4'h6,
    ST_PIN_LD  = 4'h7,
    ST_PIN_RD  = 4'h8,
    ST_STATUS  = 4'h9
  } uvt_state_t;
endpackage
`default_nettype wire

// ===== uvt_pin_test.sv
// Pin test multiplexer: loaded pin bytes, output selection and input snapshot
`timescale 1ns/1ps
`default_nettype none
module uvt_pin_test (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_test,
  input  wire logic        i_mode_ind,
  input  wire logic        i_boot_done,
  input  wire logic        i_ld_we,
  input  wire logic [1:0]  i_ld_idx,
  input  wire logic [7:0]  i_ld_data,
  input  wire logic        i_nrm_drive_reset_n,
  input  wire logic [1:0]  i_nrm_cs_n,
  input  wire logic        i_nrm_drive_power_valid,
  input  wire logic [1:0]  i_nrm_da,
  input  wire logic [2:0]  i_nrm_strobes_n,
  input  wire logic [15:0] i_nrm_dd,
  input  wire logic        i_nrm_dd_oe,
  input  wire logic        i_drive_reset_n,
  input  wire logic        i_da2,
  input  wire logic        i_intrq,
  input  wire logic        i_drive_bus_power_enable,
  input  wire logic        i_dmarq,
  input  wire logic        i_iordy,
  input  wire logic [15:0] i_dd,
  output logic             o_drive_reset_n,
  output logic             o_drive_reset_oe,
  output logic [1:0]       o_cs_n,
  output logic             o_drive_power_valid,
  output logic [1:0]       o_da,
  output logic [2:0]       o_strobes_n,
  output logic [15:0]      o_dd,
  output logic [15:0]      o_dd_oe,
  output logic [31:0]      o_snap
);
  logic [7:0] ld0_q;
  logic [7:0] ld1_q;
  logic [7:0] ld2_q;
  logic [7:0] ld3_q;
  logic [7:0] snap0;
  logic [7:0] snap1;

  // Loaded bytes hold until the next load or reset
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ld0_q <= uvt_pkg::LD0_RESET;
      ld1_q <= uvt_pkg::LD1_RESET;
      ld2_q <= uvt_pkg::LD_DD_RESET;
      ld3_q <= uvt_pkg::LD_DD_RESET;
    end else if (i_ld_we) begin
      ld0_q <= (i_ld_idx == 2'h0) ? i_ld_data : ld0_q;
      ld1_q <= (i_ld_idx == 2'h1) ? i_ld_data : ld1_q;
      ld2_q <= (i_ld_idx == 2'h2) ? i_ld_data : ld2_q;
      ld3_q <= (i_ld_idx == 2'h3) ? i_ld_data : ld3_q;
    end
  end

  // Output selection: loaded data replaces normal logic in test mode
  assign o_drive_reset_n     = i_test ? ld0_q[uvt_pkg::B0_RST] : i_nrm_drive_reset_n;
  assign o_drive_reset_oe    = i_test | i_boot_done;  // Released during boot for the strap
  assign o_cs_n              = i_test ? ld0_q[uvt_pkg::B0_CS_HI:uvt_pkg::B0_CS_LO] : i_nrm_cs_n;
  assign o_drive_power_valid = i_test ? ld0_q[uvt_pkg::B0_PWR] : i_nrm_drive_power_valid;
  assign o_da                = i_test ? ld0_q[uvt_pkg::B0_DA_HI:uvt_pkg::B0_DA_LO] : i_nrm_da;
  assign o_strobes_n         = i_test ? ld1_q[uvt_pkg::B1_DMACK:uvt_pkg::B1_DIOW] : i_nrm_strobes_n;
  assign o_dd                = i_test ? {ld3_q, ld2_q} : i_nrm_dd;
  assign o_dd_oe = {16{i_test ? ld1_q[uvt_pkg::B1_DD_OE] : i_nrm_dd_oe}};

  // Snapshot bytes built from pin levels
  assign snap0 = {i_drive_reset_n, i_da2, o_cs_n, o_drive_power_valid, o_da, i_intrq};
  assign snap1 = {1'b0, i_mode_ind, i_drive_bus_power_enable, i_dmarq, i_iordy,
                  o_strobes_n};
  assign o_snap = {i_dd[15:8], i_dd[7:0], snap1, snap0};

  // Checks on pin control
  a_dd_tristate: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_test |-> (o_dd_oe == {16{ld1_q[uvt_pkg::B1_DD_OE]}}))
    else $error("data pin enables do not follow the loaded control bit");
  a_pins_held: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_test && $past(i_test) && !$past(i_ld_we)) |-> $stable(o_dd) && $stable(o_cs_n))
    else $error("test pin outputs changed without a load");
  a_load_applied: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_test && i_ld_we && i_ld_idx == 2'h2) |=> (o_dd[7:0] == $past(i_ld_data)))
    else $error("loaded low data byte not driven on the pins");
endmodule
`default_nettype wire

// ===== uvt_cmd_decoder.sv
// Vendor command decoder for configuration memory and pin test commands
// Overview of operation
// - First block byte must match stored tag
// - Second byte 0x26 selects configuration command
// - Configuration transfer moves at most 255 bytes
// - Byte count comes from wrapper length
// - Wrapper direction flag picks load or read
// - Second byte 0x27 selects pin test command
// - Pin load enters test, pins follow data
// - Any load length, only bytes 0-3 applied
// - Test mode ends only by hard reset
// - Pin read returns one-instant sample
// - Inputs sampleable any time in test
// - Byte 0 carries reset, selects, address bits
// - Byte 1 bit 7 drives data pins, clear tri-states
// - Byte 1 mode, power, strobes, handshakes
// - Bytes 2 and 3 are data pins
// - Memory reached at physical address 2 or 4
// - Memory is 256 bytes, one-byte address
// - Boot signature selects normal or test
// - Drive reset low at boot forces test
// - Tag at byte 0x04, default 0x24
// - Signature bytes 0x00 and 0x01 checked
`timescale 1ns/1ps
`default_nettype none
module uvt_cmd_decoder #(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a,  // Arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'ha5,  // Arbitrary value
  parameter logic [2:0] MEM_PHYS  = 3'h2
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_cbw_valid,
  input  wire logic [7:0]  i_cbw_cb0,
  input  wire logic [7:0]  i_cbw_cb1,
  input  wire logic [31:0] i_cbw_len,
  input  wire logic        i_cbw_dir,
  output logic             o_cbw_ready,
  output logic             o_pass_through,
  input  wire logic        i_out_valid,
  input  wire logic [7:0]  i_out_data,
  output logic             o_out_ready,
  output logic             o_in_valid,
  output logic [7:0]       o_in_data,
  input  wire logic        i_in_ready,
  output logic             o_cmd_done,
  output logic             o_cmd_fail,
  output logic [31:0]      o_residue,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic [6:0]       o_mem_dev_addr,
  output logic [7:0]       o_mem_addr,
  output logic [7:0]       o_mem_wdata,
  input  wire logic [7:0]  i_mem_rdata,
  input  wire logic        i_mem_ack,
  input  wire logic        i_mem_nak,
  output logic [7:0]       o_vendor_tag,
  output logic             o_mfg_mode,
  output logic             o_pin_test,
  input  wire logic        i_nrm_drive_reset_n,
  input  wire logic [1:0]  i_nrm_cs_n,
  input  wire logic        i_nrm_drive_power_valid,
  input  wire logic [1:0]  i_nrm_da,
  input  wire logic [2:0]  i_nrm_strobes_n,
  input  wire logic [15:0] i_nrm_dd,
  input  wire logic        i_nrm_dd_oe,
  input  wire logic        i_drive_reset_n,
  input  wire logic        i_da2,
  input  wire logic        i_intrq,
  input  wire logic        i_drive_bus_power_enable,
  input  wire logic        i_dmarq,
  input  wire logic        i_iordy,
  input  wire logic [15:0] i_dd,
  output logic             o_drive_reset_n,
  output logic             o_drive_reset_oe,
  output logic [1:0]       o_cs_n,
  output logic             o_drive_power_valid,
  output logic [1:0]       o_da,
  output logic [2:0]       o_strobes_n,
  output logic [15:0]      o_dd,
  output logic [15:0]      o_dd_oe
);
  uvt_pkg::uvt_state_t state_q;
  uvt_pkg::uvt_state_t state_d;
  logic [1:0]  boot_idx_q;
  logic [7:0]  tag_q;
  logic        mfg_q;
  logic        test_q;
  logic        strap_low_q;
  logic        sig_ok_q;
  logic [31:0] len_q;
  logic [31:0] cnt_q;
  logic [31:0] moved_q;
  logic [7:0]  addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  in_data_q;
  logic [31:0] snap_q;
  logic        fail_q;
  logic [31:0] snap_w;
  logic        tag_hit;
  logic        is_cfg;
  logic        is_pin;
  logic        take_cbw;
  logic [31:0] cfg_len;
  logic        cnt_left;
  logic        out_take;
  logic        in_take;
  logic [7:0]  boot_addr;
  logic        ld_we;
  logic [31:0] req_len_q;

  // Command classification
  assign take_cbw  = (state_q == uvt_pkg::ST_IDLE) && i_cbw_valid;
  assign tag_hit   = (i_cbw_cb0 == tag_q);
  assign is_cfg    = tag_hit && (i_cbw_cb1 == uvt_pkg::SUB_CFG);
  assign is_pin    = tag_hit && (i_cbw_cb1 == uvt_pkg::SUB_PIN);
  assign cfg_len   = (i_cbw_len > uvt_pkg::CFG_MAX_LEN) ? uvt_pkg::CFG_MAX_LEN
                                                        : i_cbw_len;
  assign cnt_left  = (cnt_q != len_q);
  assign out_take  = o_out_ready && i_out_valid;
  assign in_take   = o_in_valid && i_in_ready;
  assign boot_addr = (boot_idx_q == 2'h0) ? uvt_pkg::SIG1_ADDR : uvt_pkg::TAG_ADDR;
  assign ld_we     = (state_q == uvt_pkg::ST_PIN_LD) && out_take && (cnt_q < uvt_pkg::PIN_DATA_LEN);

  // Handshake and status outputs
  assign o_cbw_ready    = (state_q == uvt_pkg::ST_IDLE);
  assign o_pass_through = take_cbw && !tag_hit;
  assign o_out_ready    = ((state_q == uvt_pkg::ST_CFG_WR) || (state_q == uvt_pkg::ST_PIN_LD))
                          && cnt_left;
  assign o_in_valid     = (state_q == uvt_pkg::ST_CFG_RS) || (state_q == uvt_pkg::ST_PIN_RD);
  assign o_in_data      = in_data_q;
  assign o_cmd_done     = (state_q == uvt_pkg::ST_STATUS);
  assign o_cmd_fail     = fail_q;
  assign o_residue      = req_len_q - moved_q;
  assign o_mem_req      = (state_q == uvt_pkg::ST_BOOT) || (state_q == uvt_pkg::ST_CFG_WM)
                          || (state_q == uvt_pkg::ST_CFG_RM);
  assign o_mem_we       = (state_q == uvt_pkg::ST_CFG_WM);
  assign o_mem_dev_addr = {uvt_pkg::MEM_DEV_BASE, MEM_PHYS};
  assign o_mem_addr     = addr_q;
  assign o_mem_wdata    = wdata_q;
  assign o_vendor_tag   = tag_q;
  assign o_mfg_mode     = mfg_q;
  assign o_pin_test     = test_q;

  // Next state selection
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      uvt_pkg::ST_STRAP: state_d = uvt_pkg::ST_BOOT;
      uvt_pkg::ST_BOOT: begin
        if (i_mem_nak || (i_mem_ack && boot_idx_q == 2'h2)) begin
          state_d = uvt_pkg::ST_IDLE;
        end
      end
      uvt_pkg::ST_IDLE: begin
        if (take_cbw && is_cfg) begin
          state_d = i_cbw_dir ? uvt_pkg::ST_CFG_RM : uvt_pkg::ST_CFG_WR;
          if (cfg_len == 32'h0) begin
            state_d = uvt_pkg::ST_STATUS;
          end
        end else if (take_cbw && is_pin) begin
          state_d = i_cbw_dir ? uvt_pkg::ST_PIN_RD : uvt_pkg::ST_PIN_LD;
          if (i_cbw_len == 32'h0) begin
            state_d = uvt_pkg::ST_STATUS;
          end
        end else if (take_cbw && tag_hit) begin
          state_d = uvt_pkg::ST_STATUS;
        end
      end
      uvt_pkg::ST_CFG_WR: begin
        if (!cnt_left) begin
          state_d = uvt_pkg::ST_STATUS;
        end else if (out_take) begin
          state_d = uvt_pkg::ST_CFG_WM;
        end
      end
      uvt_pkg::ST_CFG_WM: begin
        if (i_mem_nak) begin
          state_d = uvt_pkg::ST_STATUS;
        end else if (i_mem_ack) begin
          state_d = uvt_pkg::ST_CFG_WR;
        end
      end
      uvt_pkg::ST_CFG_RM: begin
        if (i_mem_nak) begin
          state_d = uvt_pkg::ST_STATUS;
        end else if (i_mem_ack) begin
          state_d = uvt_pkg::ST_CFG_RS;
        end
      end
      uvt_pkg::ST_CFG_RS: begin
        if (in_take) begin
          state_d = (cnt_q + 32'h1 == len_q) ? uvt_pkg::ST_STATUS : uvt_pkg::ST_CFG_RM;
        end
      end
      uvt_pkg::ST_PIN_LD: begin
        if (!cnt_left) begin
          state_d = uvt_pkg::ST_STATUS;
        end
      end
      uvt_pkg::ST_PIN_RD: begin
        if (in_take && (cnt_q + 32'h1 == len_q)) begin
          state_d = uvt_pkg::ST_STATUS;
        end
      end
      uvt_pkg::ST_STATUS: state_d = uvt_pkg::ST_IDLE;
      default: state_d = uvt_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= uvt_pkg::ST_STRAP;
    end else begin
      state_q <= state_d;
    end
  end

  // Boot: strap capture, signature check and tag load
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_low_q <= 1'b0;
      boot_idx_q  <= 2'h0;
      sig_ok_q    <= 1'b1;
      tag_q       <= uvt_pkg::TAG_DEFAULT;
      mfg_q       <= 1'b0;
    end else if (state_q == uvt_pkg::ST_STRAP) begin
      strap_low_q <= !i_drive_reset_n;
    end else if (state_q == uvt_pkg::ST_BOOT && i_mem_ack) begin
      boot_idx_q <= boot_idx_q + 2'h1;
      if (boot_idx_q == 2'h0) begin
        sig_ok_q <= (i_mem_rdata == SIG_BYTE0);
      end else if (boot_idx_q == 2'h1) begin
        sig_ok_q <= sig_ok_q && (i_mem_rdata == SIG_BYTE1);
      end else begin
        tag_q <= i_mem_rdata;
        mfg_q <= strap_low_q || !sig_ok_q;
      end
    end else if (state_q == uvt_pkg::ST_BOOT && i_mem_nak) begin
      mfg_q <= strap_low_q;  // No memory: default tag
    end
  end

  // Pin test mode is sticky until hard reset
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      test_q <= 1'b0;
    end else if (take_cbw && is_pin && !i_cbw_dir) begin
      test_q <= 1'b1;
    end
  end

  // Transfer length, byte counters and memory address
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      len_q   <= 32'h0;
      cnt_q   <= 32'h0;
      moved_q <= 32'h0;
      addr_q  <= uvt_pkg::SIG0_ADDR;
    end else if (take_cbw) begin
      len_q   <= is_cfg ? cfg_len : i_cbw_len;
      cnt_q   <= 32'h0;
      moved_q <= 32'h0;
      addr_q  <= uvt_pkg::CFG_START;
    end else if (state_q == uvt_pkg::ST_BOOT && i_mem_ack) begin
      addr_q <= boot_addr;  // Next address stands before the next request
    end else if (out_take || in_take) begin
      cnt_q <= cnt_q + 32'h1;
      if (state_q == uvt_pkg::ST_PIN_LD || state_q == uvt_pkg::ST_PIN_RD) begin
        moved_q <= moved_q + 32'h1;
      end
    end else if (i_mem_ack && state_q != uvt_pkg::ST_IDLE) begin
      addr_q  <= addr_q + 8'h01;
      moved_q <= moved_q + 32'h1;
    end
  end

  // Host length for the residue: keep the full request when clipped
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      req_len_q <= 32'h0;
    end else if (take_cbw) begin
      req_len_q <= i_cbw_len;
    end
  end

  // Data registers, snapshot and failure flag
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdata_q   <= 8'h00;
      in_data_q <= 8'h00;
      snap_q    <= 32'h0;
      fail_q    <= 1'b0;
    end else begin
      if (state_q == uvt_pkg::ST_CFG_WR && out_take) begin
        wdata_q <= i_out_data;
      end
      if (take_cbw) begin
        snap_q <= snap_w;
        fail_q <= tag_hit && !is_cfg && !is_pin;
      end else if (i_mem_nak && state_q != uvt_pkg::ST_BOOT) begin
        fail_q <= 1'b1;
      end
      if (state_q == uvt_pkg::ST_CFG_RM && i_mem_ack) begin
        in_data_q <= i_mem_rdata;
      end else if (take_cbw && is_pin) begin
        in_data_q <= snap_w[7:0];
      end else if (state_q == uvt_pkg::ST_PIN_RD && in_take) begin
        in_data_q <= (cnt_q + 32'h1 < uvt_pkg::PIN_DATA_LEN) ? snap_next(cnt_q, snap_q) : 8'h00;
      end
    end
  end

  // Next snapshot byte after the one being sent
  function automatic logic [7:0] snap_next(input logic [31:0] idx, input logic [31:0] s);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx[1:0])
      2'h0: b = s[15:8];
      2'h1: b = s[23:16];
      2'h2: b = s[31:24];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // Pin multiplexer and snapshot source
  uvt_pin_test u_pins (
    .i_ref_clk                (i_ref_clk),
    .i_resetn                 (i_resetn),
    .i_test                   (test_q),
    .i_mode_ind               (mfg_q | test_q),
    .i_boot_done              (state_q != uvt_pkg::ST_STRAP && state_q != uvt_pkg::ST_BOOT),
    .i_ld_we                  (ld_we),
    .i_ld_idx                 (cnt_q[1:0]),
    .i_ld_data                (i_out_data),
    .i_nrm_drive_reset_n      (i_nrm_drive_reset_n),
    .i_nrm_cs_n               (i_nrm_cs_n),
    .i_nrm_drive_power_valid  (i_nrm_drive_power_valid),
    .i_nrm_da                 (i_nrm_da),
    .i_nrm_strobes_n          (i_nrm_strobes_n),
    .i_nrm_dd                 (i_nrm_dd),
    .i_nrm_dd_oe              (i_nrm_dd_oe),
    .i_drive_reset_n          (i_drive_reset_n),
    .i_da2                    (i_da2),
    .i_intrq                  (i_intrq),
    .i_drive_bus_power_enable (i_drive_bus_power_enable),
    .i_dmarq                  (i_dmarq),
    .i_iordy                  (i_iordy),
    .i_dd                     (i_dd),
    .o_drive_reset_n          (o_drive_reset_n),
    .o_drive_reset_oe         (o_drive_reset_oe),
    .o_cs_n                   (o_cs_n),
    .o_drive_power_valid      (o_drive_power_valid),
    .o_da                     (o_da),
    .o_strobes_n              (o_strobes_n),
    .o_dd                     (o_dd),
    .o_dd_oe                  (o_dd_oe),
    .o_snap                   (snap_w)
  );

  // Sequences for the command checks
  sequence s_bad_vendor;
    take_cbw && tag_hit && !is_cfg && !is_pin;
  endsequence
  sequence s_fail_status;
    o_cmd_done && o_cmd_fail;
  endsequence

  a_bad_sub_fail: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    s_bad_vendor |=> s_fail_status)
    else $error("unknown vendor sub-command not failed");
  a_test_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    test_q |=> test_q [*8])
    else $error("pin test mode left without reset");
  a_pin_load_enter: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (take_cbw && is_pin && !i_cbw_dir) |=> test_q)
    else $error("pin load did not enter test mode");
  a_cfg_clip: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (take_cbw && is_cfg) |=> (len_q <= uvt_pkg::CFG_MAX_LEN))
    else $error("configuration transfer above limit");
  a_cfg_dir: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (take_cbw && is_cfg && i_cbw_dir && i_cbw_len != 32'h0) |=>
    (state_q == uvt_pkg::ST_CFG_RM) && !o_mem_we)
    else $error("configuration read direction not honoured");
  a_foreign_pass: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (take_cbw && i_cbw_cb0 != tag_q) |-> o_pass_through ##1 !o_cmd_done)
    else $error("foreign command not passed through");
  a_dev_address: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_mem_req |-> (o_mem_dev_addr[2:0] == uvt_pkg::PHYS_ADDR_A ||
                   o_mem_dev_addr[2:0] == uvt_pkg::PHYS_ADDR_B))
    else $error("memory device address not 2 or 4");
  a_snap_first: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (take_cbw && is_pin && i_cbw_dir) |=> (o_in_data == $past(snap_w[7:0])))
    else $error("pin read first byte not the snapshot");
endmodule
`default_nettype wire

// ===== uvt_mem_model.sv
// Serial configuration memory model on the decoder's memory port
`timescale 1ns/1ps
`default_nettype none
module uvt_mem_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_req,
  input  wire logic       i_we,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic [7:0]      o_rdata,
  output logic            o_ack
);
  logic [7:0] mem_q [256];
  int         wait_q = 0;
  // Image with valid signature and a non-default tag
  initial begin
    foreach (mem_q[i]) mem_q[i] = i[7:0];
    mem_q[0] = 8'h5a;
    mem_q[1] = 8'ha5;
    mem_q[4] = 8'h3c;
    o_ack = 1'b0;
    o_rdata = 8'h00;
  end
  // Random answer delay; data line toggles when not answering
  always @(posedge i_ref_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (wait_q == 0) begin
        o_ack <= 1'b1;
        o_rdata <= mem_q[i_addr];
        if (i_we) mem_q[i_addr] <= i_wdata;
        wait_q <= $urandom_range(3, 0);
      end else wait_q <= wait_q - 1;
    end
  end
endmodule
`default_nettype wire

// ===== test_usb_vendor_test_cmd_decoder.sv
// Self-checking bench for the vendor test command decoder
`timescale 1ns/1ps
`default_nettype none
module test_usb_vendor_test_cmd_decoder;
  logic i_ref_clk = 0, i_resetn = 0, cv = 0, cdir = 0, ov = 0;
  logic [7:0]  cb0 = 0, cb1 = 0, od = 0, b[4];
  logic [31:0] clen = 0;
  logic [15:0] dd = 0;
  logic [6:0]  pin = 0;
  int          mismatches = 0, comparisons = 0;
  wire logic   rdy, pt, ordy, iv, done, fail, mreq, mwe, ack, ptst, mfg, rstn, rsoe, pwr, rw;
  wire logic [7:0]  idt, madr, mwd, rd, tag;
  wire logic [6:0]  dev;
  wire logic [1:0]  cs, da;
  wire logic [2:0]  stb;
  wire logic [15:0] odd, ddoe, ddw;
  wire logic [31:0] res;
  // Wire levels of the shared pins
  assign ddw = (ddoe & odd) | (~ddoe & dd);
  assign rw = rsoe ? rstn : pin[0];
  always #50 i_ref_clk = ~i_ref_clk;
  uvt_cmd_decoder u_dut (.i_ref_clk, .i_resetn, .i_cbw_valid(cv), .i_cbw_cb0(cb0),
    .i_cbw_cb1(cb1), .i_cbw_len(clen), .i_cbw_dir(cdir), .o_cbw_ready(rdy),
    .o_pass_through(pt), .i_out_valid(ov), .i_out_data(od), .o_out_ready(ordy),
    .o_in_valid(iv), .o_in_data(idt), .i_in_ready(1'b1), .o_cmd_done(done),
    .o_cmd_fail(fail), .o_residue(res), .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_dev_addr(dev),
    .o_mem_addr(madr), .o_mem_wdata(mwd), .i_mem_rdata(rd), .i_mem_ack(ack), .i_mem_nak(1'b0),
    .o_vendor_tag(tag), .o_mfg_mode(mfg), .o_pin_test(ptst), .i_nrm_drive_reset_n(pin[0]),
    .i_nrm_cs_n(pin[2:1]), .i_nrm_drive_power_valid(pin[3]), .i_nrm_da(pin[5:4]),
    .i_nrm_strobes_n(pin[6:4]), .i_nrm_dd(dd), .i_nrm_dd_oe(pin[6]), .i_drive_reset_n(rw),
    .i_da2(pin[1]), .i_intrq(pin[2]), .i_drive_bus_power_enable(pin[3]), .i_dmarq(pin[4]),
    .i_iordy(pin[5]), .i_dd(ddw), .o_drive_reset_n(rstn), .o_drive_reset_oe(rsoe),
    .o_cs_n(cs), .o_drive_power_valid(pwr), .o_da(da), .o_strobes_n(stb), .o_dd(odd),
    .o_dd_oe(ddoe));
  uvt_mem_model u_mem (.i_ref_clk, .i_req(mreq), .i_we(mwe), .i_addr(madr), .i_wdata(mwd),
    .o_rdata(rd), .o_ack(ack));
  // Expected snapshot from loaded bytes and pin stimulus
  function automatic logic [31:0] exp_snap();
    logic [15:0] w = b[1][7] ? {b[3], b[2]} : dd;
    return {w, 2'b01, pin[3], pin[4], pin[5], b[1][2:0], b[0][7], pin[1], b[0][5:1], pin[2]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c0, c1, input logic [31:0] n, input logic d,
                     output logic p);
    int k = 0;
    @(posedge i_ref_clk) #1;
    cv = 1;
    cb0 = c0;
    cb1 = c1;
    clen = n;
    cdir = d;
    do begin @(negedge i_ref_clk); k++; end while (rdy !== 1'b1 && k < 500);
    if (k >= 500) mismatches++;
    p = pt;
    @(posedge i_ref_clk) #1 cv = 0;
  endtask
  task automatic put(input logic [7:0] v);
    int k = 0;
    ov = 1;
    od = v;
    do begin @(negedge i_ref_clk); k++; end while (ordy !== 1'b1 && k < 500);
    if (k >= 500) mismatches++;
    @(posedge i_ref_clk) #1;
  endtask
  task automatic get(input logic [7:0] e);
    int k = 0;
    do begin @(negedge i_ref_clk); k++; end while (iv !== 1'b1 && k < 500);
    if (k >= 500) mismatches++;
    chk(idt, e);
    @(posedge i_ref_clk);
  endtask
  task automatic fin(input logic f, input logic [31:0] r);
    int k = 0;
    do begin @(negedge i_ref_clk); k++; end while (done !== 1'b1 && k < 500);
    if (k >= 500) mismatches++;
    chk(fail, f);
    chk(res, r);
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #2_000_000;
    mismatches++;
    finish_test();
  end
  // Main sequence
  initial begin
    logic p;
    logic [7:0] r0, r1;
    void'($urandom(28768));
    pin = 7'($urandom) | 7'h01;
    dd = 16'($urandom);
    repeat (6) @(posedge i_ref_clk);
    #1 i_resetn = 1;
    for (int k = 0; k < 2000 && rdy !== 1'b1; k++) @(negedge i_ref_clk);
    chk({tag, mfg, dev}, {8'h3c, 1'b0, 7'h52});
    cmd(8'h3d, 8'h26, 1, 1, p);
    chk(p, 1);
    cmd(8'h3c, 8'h28, 4, 1, p);
    chk(p, 0);
    fin(1, 4);
    r0 = 8'($urandom);
    r1 = 8'($urandom) | 8'h40;
    cmd(8'h3c, 8'h26, 2, 0, p);
    put(r0);
    put(r1);
    ov = 0;
    fin(0, 0);
    cmd(8'h3c, 8'h26, 3, 1, p);
    get(r0);
    get(r1);
    get(8'h02);
    fin(0, 0);
    foreach (b[k]) b[k] = 8'($urandom);
    cmd(8'h3c, 8'h27, 5, 0, p);
    for (int k = 0; k < 5; k++) put(k < 4 ? b[k] : 8'hff);
    ov = 0;
    fin(0, 0);
    chk(ptst, 1);
    chk({rstn, cs, pwr, da}, {b[0][7], b[0][5:1]});
    chk({stb, ddoe}, {b[1][2:0], {16{b[1][7]}}});
    chk(odd, {b[3], b[2]});
    pin = 7'($urandom);
    dd = 16'($urandom);
    cmd(8'h3c, 8'h27, 4, 1, p);
    for (int k = 0; k < 4; k++) get(8'(exp_snap() >> (8 * k)));
    fin(0, 0);
    cmd(8'h3c, 8'h28, 1, 1, p);
    fin(1, 1);
    chk({ptst, rstn, odd}, {1'b1, b[0][7], b[3], b[2]});
    // Hard reset in mid-run: leaves pin test, loaded signature is now invalid
    pin[0] = 1'b1;
    @(posedge i_ref_clk) #1 i_resetn = 0;
    repeat (2) @(posedge i_ref_clk);
    #1 i_resetn = 1;
    for (int k = 0; k < 2000 && rdy !== 1'b1; k++) @(negedge i_ref_clk);
    chk({tag, mfg, ptst, rsoe}, {8'h3c, 3'b101});
    finish_test();
  end
endmodule
`default_nettype wire
